//--- src/emb_pkg.sv
// Constants and types shared by the external static memory bus master.
// Summary of operation
// - Data path is 8 or 16 bits, chosen at run time by configuration inputs.
// - Static asynchronous read and write cycles; page accesses only in non-multiplexed layout.
// - Four regions, each with its own chip select asserted for accesses inside it.
// - Programmable wait states per region, separately for reads and writes.
// - 16-bit mux: data and low address share ports 8/9; port 7 carries high address.
// - Multiplexed modes drive an address latch strobe of firmware-selected polarity.
// - 16-bit mux: separate low and high byte write strobes, one shared read strobe.
// - 8-bit mux: port 9 data phase drives zero on writes, ignored on reads.
// - 8-bit mux: port 7 carries the eight highest address bits unmultiplexed.
// - 8-bit mux: low byte write strobe writes data, read strobe reads.
// - 8-bit non-mux: data on port 8, 16-bit address on ports 7 and 9, no latch phase.
// - 8-bit non-mux: byte write strobe for writes, read strobe for reads.
// - With the bus disabled, ports 7, 8 and 9 follow the general purpose controls.
package emb_pkg;

  // ***************************************************************
  // Widths and field positions
  // ***************************************************************
  localparam int ADDR_W     = 24;
  localparam int DATA_W     = 16;
  localparam int WAIT_W     = 4;
  localparam int REGIONS    = 4;
  localparam int REGION_LSB = 22;
  localparam int REGION_MSB = 23;
  localparam int PAGE_LSB   = 3;
  localparam int PAGE_MSB   = 15;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h0;
  localparam logic [15:0]       DATA_RESET = 16'h0000;

  // ***************************************************************
  // Bus layouts and cycle phases
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_MUX16  = 2'b00,
    MODE_MUX8   = 2'b01,
    MODE_DEMUX8 = 2'b10
  } emb_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_HOLD    = 3'b010,
    ST_SETUP   = 3'b011,
    ST_STROBE  = 3'b100,
    ST_RECOVER = 3'b101
  } emb_state_e;

endpackage

//--- src/emb_pin_if.sv
// Interface carrying the bus-side pin drive from the sequencer to the pin multiplexer.
`timescale 1ns/1ps
interface emb_pin_if;
  logic [7:0] p7;
  logic       p7_oe;
  logic [7:0] p8;
  logic       p8_oe;
  logic [7:0] p9;
  logic       p9_oe;

  modport seq (output p7, p7_oe, p8, p8_oe, p9, p9_oe);
  modport mux (input  p7, p7_oe, p8, p8_oe, p9, p9_oe);
endinterface

//--- src/emb_wait_timer.sv
// Down counter that stretches the strobe phase by the programmed wait states.
`timescale 1ns/1ps
module emb_wait_timer #(
  parameter int W = emb_pkg::WAIT_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } emb_tmr_s;

  emb_tmr_s st;
  emb_tmr_s next_st;

  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.cnt = count_i;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // The last strobe cycle is the one in which the count has run out.
  assign done_o = !load_i && (st.cnt == '0);

endmodule // emb_wait_timer

//--- src/emb_pin_mux.sv
// Port 7, 8 and 9 ownership: bus drive while enabled, general purpose drive otherwise.
`timescale 1ns/1ps
module emb_pin_mux (
  input  wire logic       bus_en_i,
  emb_pin_if.mux          bus,
  input  wire logic [7:0] gp7_i,
  input  wire logic       gp7_oe_i,
  input  wire logic [7:0] gp8_i,
  input  wire logic       gp8_oe_i,
  input  wire logic [7:0] gp9_i,
  input  wire logic       gp9_oe_i,
  output logic      [7:0] p7_o,
  output logic            p7_oe_o,
  output logic      [7:0] p8_o,
  output logic            p8_oe_o,
  output logic      [7:0] p9_o,
  output logic            p9_oe_o
);

  always_comb begin
    if (bus_en_i) begin
      p7_o    = bus.p7;
      p7_oe_o = bus.p7_oe;
      p8_o    = bus.p8;
      p8_oe_o = bus.p8_oe;
      p9_o    = bus.p9;
      p9_oe_o = bus.p9_oe;
    end else begin
      p7_o    = gp7_i;
      p7_oe_o = gp7_oe_i;
      p8_o    = gp8_i;
      p8_oe_o = gp8_oe_i;
      p9_o    = gp9_i;
      p9_oe_o = gp9_oe_i;
    end
  end

endmodule // emb_pin_mux

//--- src/emb_core.sv
// External static memory bus master: cycle sequencer, region decode and strobes.
`timescale 1ns/1ps
module emb_core #(
  parameter int WAIT_W  = emb_pkg::WAIT_W,
  parameter int REGIONS = emb_pkg::REGIONS
) (
  input  wire logic                      CLK_I,
  input  wire logic                      RST_I,
  // Configuration.
  input  wire logic                      BUS_EN_I,
  input  wire logic [1:0]                MODE_I,
  input  wire logic                      ALE_POL_I,
  input  wire logic                      PAGE_EN_I,
  input  wire logic [REGIONS*WAIT_W-1:0] RD_WAIT_I,
  input  wire logic [REGIONS*WAIT_W-1:0] WR_WAIT_I,
  // Request and answer.
  input  wire logic                      REQ_VALID_I,
  output logic                           REQ_READY_O,
  input  wire logic                      REQ_WRITE_I,
  input  wire logic [23:0]               REQ_ADDR_I,
  input  wire logic [15:0]               REQ_WDATA_I,
  input  wire logic [1:0]                REQ_BE_I,
  output logic                           RSP_VALID_O,
  output logic      [15:0]               RSP_RDATA_O,
  output logic                           BUSY_O,
  // General purpose drive of the shared ports.
  input  wire logic [7:0]                GP7_I,
  input  wire logic                      GP7_OE_I,
  input  wire logic [7:0]                GP8_I,
  input  wire logic                      GP8_OE_I,
  input  wire logic [7:0]                GP9_I,
  input  wire logic                      GP9_OE_I,
  // Pins.
  output logic      [7:0]                P7_O,
  output logic                           P7_OE_O,
  output logic      [7:0]                P8_O,
  output logic                           P8_OE_O,
  input  wire logic [7:0]                P8_I,
  output logic      [7:0]                P9_O,
  output logic                           P9_OE_O,
  input  wire logic [7:0]                P9_I,
  output logic      [REGIONS-1:0]        REGION_SELECT_N_O,
  output logic                           ADDRESS_LATCH_STROBE_O,
  output logic                           LOW_BYTE_WRITE_STROBE_N_O,
  output logic                           HIGH_BYTE_WRITE_STROBE_N_O,
  output logic                           READ_STROBE_N_O,
  output logic                           BYTE_WRITE_STROBE_N_O
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [1:0] region_of(input logic [23:0] a);
    region_of = a[emb_pkg::REGION_MSB:emb_pkg::REGION_LSB];
  endfunction

  function automatic logic [WAIT_W-1:0] wait_of(input logic [REGIONS*WAIT_W-1:0] v,
                                                input logic [1:0]                r);
    wait_of = v[r*WAIT_W +: WAIT_W];
  endfunction

  function automatic logic [WAIT_W-1:0] wait_for(input logic                      wr,
                                                 input logic [REGIONS*WAIT_W-1:0] rd_v,
                                                 input logic [REGIONS*WAIT_W-1:0] wr_v,
                                                 input logic [23:0]               a);
    wait_for = wr ? wait_of(wr_v, region_of(a)) : wait_of(rd_v, region_of(a));
  endfunction

  function automatic emb_pkg::emb_mode_e mode_of(input logic [1:0] m);
    unique case (m)
      2'b00:   mode_of = emb_pkg::MODE_MUX16;
      2'b01:   mode_of = emb_pkg::MODE_MUX8;
      default: mode_of = emb_pkg::MODE_DEMUX8;
    endcase
  endfunction

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    emb_pkg::emb_state_e st;
    emb_pkg::emb_mode_e  mode;
    logic                write;
    logic [23:0]         addr;
    logic [15:0]         wdata;
    logic [1:0]          be;
    logic                rsp_valid;
    logic [15:0]         rdata;
  } emb_core_s;

  emb_core_s cur;
  emb_core_s next_cur;

  logic              tmr_load;
  logic [WAIT_W-1:0] tmr_count;
  logic              tmr_done;
  logic              accept;
  logic              page_hit;
  logic              is_mux;

  emb_pin_if pins ();

  // A page access keeps the select asserted and goes straight back to the
  // strobe, so only a same-direction access inside the same page qualifies.
  assign page_hit = (cur.st == emb_pkg::ST_RECOVER) && PAGE_EN_I
                  && (cur.mode == emb_pkg::MODE_DEMUX8)
                  && (mode_of(MODE_I) == emb_pkg::MODE_DEMUX8)
                  && (REQ_WRITE_I == cur.write)
                  && (region_of(REQ_ADDR_I) == region_of(cur.addr))
                  && (REQ_ADDR_I[emb_pkg::PAGE_MSB:emb_pkg::PAGE_LSB]
                      == cur.addr[emb_pkg::PAGE_MSB:emb_pkg::PAGE_LSB]);

  assign REQ_READY_O = BUS_EN_I && ((cur.st == emb_pkg::ST_IDLE) || page_hit);
  assign accept      = REQ_VALID_I && REQ_READY_O;
  assign is_mux      = (cur.mode != emb_pkg::MODE_DEMUX8);

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  // A multiplexed access runs address, hold, 1+W strobe cycles and recovery;
  // the non-multiplexed one trades the two latch cycles for one setup cycle.
  // Recovery always lifts the strobes, so back-to-back accesses never merge.
  always_comb begin
    next_cur           = cur;
    next_cur.rsp_valid = 1'b0;
    tmr_load           = 1'b0;
    tmr_count          = emb_pkg::WAIT_RESET;
    unique case (cur.st)
      emb_pkg::ST_IDLE, emb_pkg::ST_RECOVER: begin
        next_cur.st = emb_pkg::ST_IDLE;
        if (accept) begin
          next_cur.mode  = mode_of(MODE_I);
          next_cur.write = REQ_WRITE_I;
          next_cur.addr  = REQ_ADDR_I;
          next_cur.wdata = REQ_WDATA_I;
          next_cur.be    = REQ_BE_I;
          if (page_hit) begin
            next_cur.st = emb_pkg::ST_STROBE;
            tmr_load    = 1'b1;
            tmr_count   = wait_for(REQ_WRITE_I, RD_WAIT_I, WR_WAIT_I, REQ_ADDR_I);
          end else if (mode_of(MODE_I) == emb_pkg::MODE_DEMUX8) begin
            next_cur.st = emb_pkg::ST_SETUP;
          end else begin
            next_cur.st = emb_pkg::ST_ADDR;
          end
        end
      end
      emb_pkg::ST_ADDR: begin
        next_cur.st = emb_pkg::ST_HOLD;
      end
      emb_pkg::ST_HOLD, emb_pkg::ST_SETUP: begin
        next_cur.st = emb_pkg::ST_STROBE;
        tmr_load    = 1'b1;
        tmr_count   = wait_for(cur.write, RD_WAIT_I, WR_WAIT_I, cur.addr);
      end
      emb_pkg::ST_STROBE: begin
        if (tmr_done) begin
          next_cur.st        = emb_pkg::ST_RECOVER;
          next_cur.rsp_valid = 1'b1;
          if (!cur.write) begin
            // Port 9 carries no data in the 8-bit layouts and reads as zero.
            next_cur.rdata = (cur.mode == emb_pkg::MODE_MUX16) ? {P9_I, P8_I}
                                                               : {8'h00, P8_I};
          end
        end
      end
      default: begin
        next_cur.st = emb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cur           <= '0;
      cur.st        <= emb_pkg::ST_IDLE;
      cur.mode      <= emb_pkg::MODE_MUX16;
      cur.rdata     <= emb_pkg::DATA_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  emb_wait_timer #(
    .W (WAIT_W)
  ) u_timer (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  // ***************************************************************
  // Bus drive
  // ***************************************************************
  logic addr_phase;
  logic data_phase;
  logic select_on;

  assign addr_phase = (cur.st == emb_pkg::ST_ADDR) || (cur.st == emb_pkg::ST_HOLD);
  assign data_phase = (cur.st == emb_pkg::ST_STROBE);
  // The select stays low through recovery only in page mode, so that a
  // following page hit needs no new setup phase.
  assign select_on  = (cur.st == emb_pkg::ST_ADDR) || (cur.st == emb_pkg::ST_HOLD)
                   || (cur.st == emb_pkg::ST_SETUP) || data_phase
                   || ((cur.st == emb_pkg::ST_RECOVER) && PAGE_EN_I && !is_mux);

  always_comb begin
    pins.p7    = 8'h00;
    pins.p7_oe = 1'b0;
    pins.p8    = 8'h00;
    pins.p8_oe = 1'b0;
    pins.p9    = 8'h00;
    pins.p9_oe = 1'b0;
    if (cur.st != emb_pkg::ST_IDLE) begin
      pins.p7_oe = 1'b1;
      if (is_mux) begin
        pins.p7 = cur.addr[23:16];
        if (addr_phase) begin
          pins.p8    = cur.addr[7:0];
          pins.p9    = cur.addr[15:8];
          pins.p8_oe = 1'b1;
          pins.p9_oe = 1'b1;
        end else if (data_phase && cur.write) begin
          pins.p8    = cur.wdata[7:0];
          pins.p9    = (cur.mode == emb_pkg::MODE_MUX16) ? cur.wdata[15:8] : 8'h00;
          pins.p8_oe = 1'b1;
          pins.p9_oe = 1'b1;
        end
      end else begin
        pins.p7    = cur.addr[15:8];
        pins.p9    = cur.addr[7:0];
        pins.p9_oe = 1'b1;
        pins.p8    = cur.wdata[7:0];
        pins.p8_oe = cur.write && (data_phase || (cur.st == emb_pkg::ST_SETUP));
      end
    end
  end

  emb_pin_mux u_pins (
    .bus_en_i (BUS_EN_I),
    .bus      (pins.mux),
    .gp7_i    (GP7_I),
    .gp7_oe_i (GP7_OE_I),
    .gp8_i    (GP8_I),
    .gp8_oe_i (GP8_OE_I),
    .gp9_i    (GP9_I),
    .gp9_oe_i (GP9_OE_I),
    .p7_o     (P7_O),
    .p7_oe_o  (P7_OE_O),
    .p8_o     (P8_O),
    .p8_oe_o  (P8_OE_O),
    .p9_o     (P9_O),
    .p9_oe_o  (P9_OE_O)
  );

  // ***************************************************************
  // Selects and strobes
  // ***************************************************************
  always_comb begin
    REGION_SELECT_N_O = '1;
    if (select_on) begin
      REGION_SELECT_N_O[region_of(cur.addr)] = 1'b0;
    end
  end

  // Latch strobe is active only in the first address cycle of a multiplexed
  // cycle; the hold cycle keeps the address stable past its trailing edge.
  assign ADDRESS_LATCH_STROBE_O = ((cur.st == emb_pkg::ST_ADDR) && is_mux) ? ALE_POL_I
                                                                           : !ALE_POL_I;

  assign READ_STROBE_N_O = !(data_phase && !cur.write);

  assign LOW_BYTE_WRITE_STROBE_N_O  = !(data_phase && cur.write && is_mux
                                        && ((cur.mode == emb_pkg::MODE_MUX8) || cur.be[0]));
  assign HIGH_BYTE_WRITE_STROBE_N_O = !(data_phase && cur.write
                                        && (cur.mode == emb_pkg::MODE_MUX16) && cur.be[1]);
  assign BYTE_WRITE_STROBE_N_O      = !(data_phase && cur.write && !is_mux);

  // ***************************************************************
  // Answer
  // ***************************************************************
  assign RSP_VALID_O = cur.rsp_valid;
  assign RSP_RDATA_O = cur.rdata;
  assign BUSY_O      = (cur.st != emb_pkg::ST_IDLE);

endmodule // emb_core

//--- dv/emb_mem_model.sv
// Behavioural static memory with address latch, seen on ports 7, 8 and 9.
`timescale 1ns/1ps
module emb_mem_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       ale_pol_i,
  input  wire logic       ale_i,
  input  wire logic [3:0] sel_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wrl_n_i,
  input  wire logic       wrh_n_i,
  input  wire logic       bwr_n_i,
  input  wire logic [7:0] p7_i,
  input  wire logic [7:0] p8_i,
  input  wire logic [7:0] p9_i,
  output logic      [7:0] p8_o,
  output logic      [7:0] p9_o
);
  logic [7:0]  mem [int];
  logic [23:0] lat;
  logic [7:0]  l8 = 8'h00;
  logic [7:0]  l9 = 8'h00;
  int          a;
  int          rc = 0;
  function automatic logic [7:0] rd(int k);
    return mem.exists(k) ? mem[k] : k[7:0] ^ 8'h5a;
  endfunction
  // Transparent while the latch strobe is active, like the external latch part.
  always_latch if (ale_i == ale_pol_i) lat <= {p7_i, p9_i, p8_i};
  assign a = mode_i[1] ? int'({p7_i, p9_i}) : mode_i[0] ? int'(lat) : int'({lat[23:1], 1'b0});
  always @(posedge clk_i) begin
    if (!wrl_n_i && !mode_i[1]) mem[a] = p8_i;
    if (!wrh_n_i && mode_i == 2'h0) mem[a + 1] = p9_i;
    if (!bwr_n_i && mode_i[1]) mem[a] = p8_i;
    rc <= rd_n_i ? 0 : rc + 1;
    l8 <= p8_o;
    l9 <= p9_o;
  end
  // Region 3 is a slow part: its data is garbage during the first two cycles of the strobe.
  always @* begin
    p8_o = ~l8;
    p9_o = ~l9;
    if (!rd_n_i && (sel_n_i[3] || rc >= 2)) begin
      p8_o = rd(a);
      if (mode_i == 2'h0) p9_o = rd(a + 1);
    end
  end
endmodule // emb_mem_model

//--- dv/emb_core_chk.sv
// Assertion checker for the external static memory bus master.
`timescale 1ns/1ps
module emb_core_chk #(
  parameter int WAIT_W  = 4,
  parameter int REGIONS = 4
) (
  input wire logic                      CLK_I,
  input wire logic                      RST_I,
  input wire logic                      BUS_EN_I,
  input wire logic [1:0]                MODE_I,
  input wire logic                      ALE_POL_I,
  input wire logic                      PAGE_EN_I,
  input wire logic [REGIONS*WAIT_W-1:0] RD_WAIT_I,
  input wire logic [REGIONS*WAIT_W-1:0] WR_WAIT_I,
  input wire logic                      REQ_VALID_I,
  input wire logic                      REQ_READY_O,
  input wire logic                      REQ_WRITE_I,
  input wire logic [23:0]               REQ_ADDR_I,
  input wire logic                      RSP_VALID_O,
  input wire logic                      BUSY_O,
  input wire logic [7:0]                GP7_I,
  input wire logic                      GP7_OE_I,
  input wire logic [7:0]                P7_O,
  input wire logic                      P7_OE_O,
  input wire logic [7:0]                P9_O,
  input wire logic                      P9_OE_O,
  input wire logic [REGIONS-1:0]        REGION_SELECT_N_O,
  input wire logic                      ADDRESS_LATCH_STROBE_O,
  input wire logic                      LOW_BYTE_WRITE_STROBE_N_O,
  input wire logic                      HIGH_BYTE_WRITE_STROBE_N_O,
  input wire logic                      READ_STROBE_N_O,
  input wire logic                      BYTE_WRITE_STROBE_N_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic        acc;
  logic [1:0]  rg;
  int unsigned cnt, lat, w;
  logic        wl, wh, rdl, bw;
  assign {wl, wh, rdl, bw} = ~{LOW_BYTE_WRITE_STROBE_N_O, HIGH_BYTE_WRITE_STROBE_N_O,
                               READ_STROBE_N_O, BYTE_WRITE_STROBE_N_O};
  assign acc = REQ_VALID_I && REQ_READY_O;
  assign w = REQ_WRITE_I ? WR_WAIT_I[REQ_ADDR_I[23:22]*WAIT_W +: WAIT_W]
                         : RD_WAIT_I[REQ_ADDR_I[23:22]*WAIT_W +: WAIT_W];
  // Cycles since the last accepted request, and the answer cycle it must land on.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rg  <= 2'h0;
      cnt <= 0;
      lat <= 0;
    end else if (acc) begin
      rg  <= REQ_ADDR_I[23:22];
      cnt <= 1;
      lat <= BUSY_O ? 2 + w : MODE_I[1] ? 3 + w : 4 + w;
    end else begin
      cnt <= cnt + 1;
    end
  end
  lat_match_a: assert property (RSP_VALID_O |-> cnt == lat)
    else $error("response not at the programmed wait count");
  sel_match_a: assert property (REGION_SELECT_N_O != '1 |->
                                REGION_SELECT_N_O == ~(REGIONS'(1) << rg))
    else $error("wrong region select");
  gp_follow_a: assert property (!BUS_EN_I |-> P7_O == GP7_I && P7_OE_O == GP7_OE_I)
    else $error("port 7 not released to general purpose drive");
  no_ready_a: assert property (!BUS_EN_I |-> !REQ_READY_O)
    else $error("request taken while bus disabled");
  mux8_zero_a: assert property (BUS_EN_I && MODE_I == 2'h1 && wl |->
                                P9_O == 8'h00 && P9_OE_O)
    else $error("port 9 not zero in byte write");
  rd_excl_a: assert property (rdl |-> !(wl || wh || bw))
    else $error("read and write strobes together");
  strobe_kind_a: assert property (MODE_I[1] ? !(wl || wh) :
                                  !bw && !(MODE_I[0] && wh))
    else $error("write strobe of the wrong layout");
  sel_strobe_a: assert property (rdl || wl || wh || bw |-> REGION_SELECT_N_O != '1)
    else $error("strobe without select");
  rsp_idle_a: assert property (RSP_VALID_O |-> !(rdl || wl || wh || bw) &&
                               (PAGE_EN_I || REGION_SELECT_N_O == '1))
    else $error("strobes or select active at completion");
  ale_rest_a: assert property (!BUSY_O || MODE_I[1] |->
                               ADDRESS_LATCH_STROBE_O == !ALE_POL_I)
    else $error("latch strobe active outside address phase");
  ale_pulse_a: assert property (acc && !BUSY_O && !MODE_I[1] |=>
                                ADDRESS_LATCH_STROBE_O == ALE_POL_I
                                ##1 ADDRESS_LATCH_STROBE_O != ALE_POL_I)
    else $error("latch strobe pulse wrong");
  cover property (acc && BUSY_O);
  cover property (MODE_I == 2'h1 && wl);
  cover property (!BUS_EN_I);
endmodule // emb_core_chk
bind emb_core emb_core_chk #(.WAIT_W(WAIT_W), .REGIONS(REGIONS)) emb_core_chk_i (
  .CLK_I, .RST_I, .BUS_EN_I, .MODE_I, .ALE_POL_I, .PAGE_EN_I, .RD_WAIT_I, .WR_WAIT_I,
  .REQ_VALID_I, .REQ_READY_O, .REQ_WRITE_I, .REQ_ADDR_I, .RSP_VALID_O, .BUSY_O, .GP7_I,
  .GP7_OE_I, .P7_O, .P7_OE_O, .P9_O, .P9_OE_O, .REGION_SELECT_N_O, .ADDRESS_LATCH_STROBE_O,
  .LOW_BYTE_WRITE_STROBE_N_O, .HIGH_BYTE_WRITE_STROBE_N_O, .READ_STROBE_N_O,
  .BYTE_WRITE_STROBE_N_O);

//--- dv/test_emb_core.sv
// Self-checking testbench of the external static memory bus master.
`timescale 1ns/1ps
module test_emb_core;
  logic CLK_I, RST_I, BUS_EN_I, ALE_POL_I, PAGE_EN_I, REQ_VALID_I, REQ_WRITE_I;
  logic [1:0] MODE_I, REQ_BE_I;
  logic [15:0] RD_WAIT_I, WR_WAIT_I, REQ_WDATA_I, RSP_RDATA_O;
  logic [23:0] REQ_ADDR_I;
  logic REQ_READY_O, RSP_VALID_O, BUSY_O, GP7_OE_I, GP8_OE_I, GP9_OE_I, P7_OE_O, P8_OE_O, P9_OE_O;
  logic [7:0] GP7_I, GP8_I, GP9_I, P7_O, P8_O, P9_O, P8_I, P9_I, m8, m9;
  logic [3:0] REGION_SELECT_N_O;
  logic ADDRESS_LATCH_STROBE_O, LOW_BYTE_WRITE_STROBE_N_O, HIGH_BYTE_WRITE_STROBE_N_O;
  logic READ_STROBE_N_O, BYTE_WRITE_STROBE_N_O;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int q_t[$], q_l[$], q_d[$];
  logic [7:0] ref_m [int];
  logic [23:0] ad;
  emb_core emb_core_i (.CLK_I, .RST_I, .BUS_EN_I, .MODE_I, .ALE_POL_I, .PAGE_EN_I, .RD_WAIT_I,
    .WR_WAIT_I, .REQ_VALID_I, .REQ_READY_O, .REQ_WRITE_I, .REQ_ADDR_I, .REQ_WDATA_I, .REQ_BE_I,
    .RSP_VALID_O, .RSP_RDATA_O, .BUSY_O, .GP7_I, .GP7_OE_I, .GP8_I, .GP8_OE_I, .GP9_I, .GP9_OE_I,
    .P7_O, .P7_OE_O, .P8_O, .P8_OE_O, .P8_I, .P9_O, .P9_OE_O, .P9_I, .REGION_SELECT_N_O,
    .ADDRESS_LATCH_STROBE_O, .LOW_BYTE_WRITE_STROBE_N_O, .HIGH_BYTE_WRITE_STROBE_N_O,
    .READ_STROBE_N_O, .BYTE_WRITE_STROBE_N_O);
  // The wire level: the master wins while it drives, else the memory model.
  assign P8_I = P8_OE_O ? P8_O : m8;
  assign P9_I = P9_OE_O ? P9_O : m9;
  emb_mem_model emb_mem_model_i (.clk_i(CLK_I), .mode_i(MODE_I), .ale_pol_i(ALE_POL_I),
    .ale_i(ADDRESS_LATCH_STROBE_O), .sel_n_i(REGION_SELECT_N_O), .rd_n_i(READ_STROBE_N_O),
    .wrl_n_i(LOW_BYTE_WRITE_STROBE_N_O), .wrh_n_i(HIGH_BYTE_WRITE_STROBE_N_O),
    .bwr_n_i(BYTE_WRITE_STROBE_N_O), .p7_i(P7_O), .p8_i(P8_I), .p9_i(P9_I), .p8_o(m8), .p9_o(m9));
  always #20 CLK_I = ~CLK_I;
  always @(posedge CLK_I) cyc <= cyc + 1;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic int key(logic [1:0] m, logic [23:0] a);
    return m[1] ? int'(a[15:0]) : m[0] ? int'(a) : int'({a[23:1], 1'b0});
  endfunction
  function automatic logic [7:0] rb(int k);
    return ref_m.exists(k) ? ref_m[k] : k[7:0] ^ 8'h5a;
  endfunction
  // Called at a rising edge; returns at the edge that takes the request.
  task automatic issue(input logic w, input logic [23:0] a, input logic [15:0] d,
                       input logic [1:0] be, input bit pg);
    int k, wt, n;
    k = key(MODE_I, a);
    wt = w ? WR_WAIT_I[a[23:22]*4 +: 4] : RD_WAIT_I[a[23:22]*4 +: 4];
    {REQ_WRITE_I, REQ_ADDR_I, REQ_WDATA_I, REQ_BE_I, REQ_VALID_I} <= {w, a, d, be, 1'b1};
    n = 0;
    do begin @(negedge CLK_I); n++; end while (REQ_READY_O !== 1'b1 && n < 60);
    chk(16'(n < 60), 16'h1);
    q_t.push_back(cyc);
    q_l.push_back(pg ? 2 + wt : MODE_I[1] ? 3 + wt : 4 + wt);
    if (w) begin
      if (MODE_I != 2'h0 || be[0]) ref_m[k] = d[7:0];
      if (MODE_I == 2'h0 && be[1]) ref_m[k + 1] = d[15:8];
      q_d.push_back(-1);
    end else begin
      q_d.push_back(int'(MODE_I == 2'h0 ? {rb(k + 1), rb(k)} : {8'h00, rb(k)}));
    end
    @(posedge CLK_I);
  endtask
  task automatic drain();
    int n;
    n = 0;
    REQ_VALID_I <= 1'b0;
    while (q_t.size() > 0 && n < 200) begin @(posedge CLK_I); n++; end
    chk(16'(n < 200), 16'h1);
    @(posedge CLK_I);
  endtask
  always @(negedge CLK_I) begin
    if (RSP_VALID_O === 1'b1) begin
      if (q_t.size() == 0) chk(16'h0, 16'h1);
      else begin
        chk(16'(cyc - q_t.pop_front()), 16'(q_l.pop_front()));
        if (q_d[0] >= 0) chk(RSP_RDATA_O, 16'(q_d[0]));
        void'(q_d.pop_front());
      end
    end
  end
  initial begin
    #(40 * 20000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(70));
    CLK_I = 0; RST_I = 1; BUS_EN_I = 1; MODE_I = 2'h0; ALE_POL_I = 0; PAGE_EN_I = 0;
    RD_WAIT_I = {4'($urandom_range(15, 2)), 12'($urandom) & 12'hff0};
    WR_WAIT_I = {12'($urandom), 4'hf};
    {REQ_VALID_I, REQ_WRITE_I, REQ_ADDR_I, REQ_WDATA_I, REQ_BE_I} = '0;
    {GP7_I, GP7_OE_I, GP8_I, GP8_OE_I, GP9_I, GP9_OE_I} = 27'($urandom);
    repeat (8) @(posedge CLK_I);
    RST_I <= 0;
    @(posedge CLK_I);
    // Every layout, both latch polarities, every region: write then read back.
    for (int m = 0; m < 4; m++) begin
      MODE_I <= 2'(m);
      ALE_POL_I <= m[0];
      @(posedge CLK_I);
      for (int r = 0; r < 4; r++) begin
        ad = {2'(r), 22'($urandom)} & 24'hfffffe;
        issue(1, ad, 16'($urandom), 2'($urandom_range(3, 1)), 0);
        issue(0, ad, 16'h0, 2'h0, 0);
      end
      drain();
    end
    // Page reads only hit in the non-multiplexed layout.
    for (int m = 0; m < 4; m += 2) begin
      MODE_I <= 2'(m);
      PAGE_EN_I <= 1;
      @(posedge CLK_I);
      ad = 24'($urandom) & 24'hfffff0;
      issue(0, ad, 16'h0, 2'h0, 0);
      issue(0, ad | 24'h2, 16'h0, 2'h0, m[1]);
      issue(1, ad | 24'h4, 16'($urandom), 2'h3, 0);
      drain();
    end
    BUS_EN_I <= 0;
    {GP7_I, GP7_OE_I, GP8_I, GP8_OE_I, GP9_I, GP9_OE_I} <= 27'($urandom);
    repeat (2) @(negedge CLK_I);
    chk({P7_O, P8_O}, {GP7_I, GP8_I});
    chk({P9_O, 8'h00}, {GP9_I, 8'h00});
    chk({13'h0, P7_OE_O, P8_OE_O, P9_OE_O}, {13'h0, GP7_OE_I, GP8_OE_I, GP9_OE_I});
    chk(16'(REQ_READY_O), 16'h0);
    tally_and_finish();
  end
endmodule // test_emb_core
